// ===== logic/aspc_pkg.sv
// package: register map, field layout, modes and reset values of the axis stop/commit block
package aspc_pkg;
  localparam int unsigned ASPC_ADDR_W = 8;
  localparam logic [7:0] ASPC_OFS_CMD = 8'h00;
  localparam logic [7:0] ASPC_OFS_MODE = 8'h04;
  localparam logic [7:0] ASPC_OFS_ACC = 8'h08;
  localparam logic [7:0] ASPC_OFS_VEL = 8'h0c;
  localparam logic [7:0] ASPC_OFS_TGT = 8'h10;
  localparam logic [7:0] ASPC_OFS_STAT = 8'h14;
  localparam logic [7:0] ASPC_OFS_IRQ_ST = 8'h18;
  localparam logic [7:0] ASPC_OFS_IRQ_MSK = 8'h1c;
  localparam logic [7:0] ASPC_OFS_ACT_POS = 8'h20;
  localparam logic [7:0] ASPC_OFS_PLAN_POS = 8'h24;
  localparam logic [7:0] ASPC_OFS_CUR_VEL = 8'h28;
  localparam logic [7:0] ASPC_OFS_PERIOD = 8'h2c;
  // command register bits (write one to queue; the commit bit issues them)
  localparam int unsigned ASPC_CMD_COMMIT = 0;
  localparam int unsigned ASPC_CMD_SMOOTH = 1;
  localparam int unsigned ASPC_CMD_ABRUPT = 2;
  localparam int unsigned ASPC_CMD_SYNC = 3;
  localparam int unsigned ASPC_CMD_ZERO = 4;
  localparam int unsigned ASPC_CMD_STEPDIR = 5;
  localparam int unsigned ASPC_CMD_DUAL = 6;
  localparam int unsigned ASPC_CMD_W = 7;
  // mode register: [1:0] motion mode, [2] pulse output mode
  localparam int unsigned ASPC_MODE_PULSE_BIT = 2;
  // status bits
  localparam int unsigned ASPC_ST_MOVING = 0;
  localparam int unsigned ASPC_ST_DUAL = 1;
  localparam int unsigned ASPC_ST_ERR = 2;
  // interrupt status bits
  localparam int unsigned ASPC_IRQ_ILLEGAL = 0;
  localparam int unsigned ASPC_IRQ_STOPPED = 1;
  localparam int unsigned ASPC_IRQ_COMMIT = 2;
  localparam int unsigned ASPC_IRQ_W = 3;
  localparam logic [31:0] ASPC_PERIOD_RST = 32'h0000_9c40;
  localparam logic [31:0] ASPC_ZERO32 = 32'h0000_0000;
  typedef enum logic [1:0] {
    ASPC_TRAP,
    ASPC_SCURVE,
    ASPC_VELOCITY,
    ASPC_GEAR
  } aspc_motion_t;
endpackage

// ===== logic/aspc_period_tick.sv
// servo period tick generator
module aspc_period_tick (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [31:0] period_in,
  output logic tick_out
);
  import aspc_pkg::*;
  logic [31:0] cnt_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= ASPC_ZERO32;
      tick_out <= 1'b0;
    end else if (cnt_r + 32'h1 >= period_in) begin
      cnt_r <= ASPC_ZERO32;
      tick_out <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      tick_out <= 1'b0;
    end
  end
endmodule

// ===== logic/aspc_pulse_gen.sv
// pulse generator: step+direction or separate forward/reverse pulses
module aspc_pulse_gen (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic step_in,
  input wire logic dir_neg_in,
  input wire logic dual_in,
  output logic step_out,
  output logic dir_out,
  output logic fwd_out,
  output logic rev_out
);
  import aspc_pkg::*;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      step_out <= 1'b0;
      dir_out <= 1'b0;
      fwd_out <= 1'b0;
      rev_out <= 1'b0;
    end else begin
      step_out <= step_in & ~dual_in;
      dir_out <= dual_in ? 1'b0 : dir_neg_in;
      fwd_out <= step_in & dual_in & ~dir_neg_in;
      rev_out <= step_in & dual_in & dir_neg_in;
    end
  end
endmodule

// ===== logic/aspc_axis.sv
// axis stop, position commit and pulse method logic with APB register slave
module aspc_axis (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [aspc_pkg::ASPC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic step_out,
  output logic dir_out,
  output logic fwd_out,
  output logic rev_out,
  output logic irq_out
);
  import aspc_pkg::*;

  // ****************************************************
  // bus decode
  // ****************************************************
  logic wr_en, rd_en, addr_ok;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;
  always_comb begin
    case (paddr)
      ASPC_OFS_CMD, ASPC_OFS_MODE, ASPC_OFS_ACC, ASPC_OFS_VEL, ASPC_OFS_TGT,
      ASPC_OFS_STAT, ASPC_OFS_IRQ_ST, ASPC_OFS_IRQ_MSK, ASPC_OFS_ACT_POS,
      ASPC_OFS_PLAN_POS, ASPC_OFS_CUR_VEL, ASPC_OFS_PERIOD: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;

  // ****************************************************
  // shadow (buffered) registers, the directly written period register and pending commands
  // ****************************************************
  logic [31:0] acc_buf_r, vel_buf_r, tgt_buf_r, period_r;
  logic [2:0] mode_buf_r;
  logic [ASPC_CMD_W-1:0] pend_r;
  logic commit;
  assign commit = wr_en & (paddr == ASPC_OFS_CMD) & pwdata[ASPC_CMD_COMMIT];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_buf_r <= ASPC_ZERO32;
      vel_buf_r <= ASPC_ZERO32;
      tgt_buf_r <= ASPC_ZERO32;
      mode_buf_r <= 3'h0;
      period_r <= ASPC_PERIOD_RST;
    end else if (wr_en) begin
      case (paddr)
        ASPC_OFS_ACC: acc_buf_r <= pwdata;
        ASPC_OFS_VEL: vel_buf_r <= pwdata;
        ASPC_OFS_TGT: tgt_buf_r <= pwdata;
        ASPC_OFS_MODE: mode_buf_r <= pwdata[2:0];
        ASPC_OFS_PERIOD: period_r <= pwdata;
        default: ;
      endcase
    end
  end

  // commands wait in the buffer; a commit in the same write also takes them
  logic [ASPC_CMD_W-1:0] cmd_wr, cmd_go;
  assign cmd_wr = (wr_en && paddr == ASPC_OFS_CMD) ? pwdata[ASPC_CMD_W-1:0] : '0;
  assign cmd_go = commit ? (pend_r | cmd_wr) : '0;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_r <= '0;
    end else if (commit) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_r | cmd_wr;
    end
  end

  // ****************************************************
  // active parameters
  // ****************************************************
  logic [31:0] acc_r, vel_r, tgt_r, act_r, plan_r, cur_vel_r;
  aspc_motion_t motion_r;
  logic pulse_mode_r, dual_r, moving;
  logic gear;
  assign gear = (motion_r == ASPC_GEAR);
  assign moving = (cur_vel_r != ASPC_ZERO32);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_r <= ASPC_ZERO32;
      vel_r <= ASPC_ZERO32;
      motion_r <= ASPC_TRAP;
      pulse_mode_r <= 1'b0;
    end else if (commit) begin
      acc_r <= acc_buf_r;
      vel_r <= vel_buf_r;
      motion_r <= aspc_motion_t'(mode_buf_r[1:0]);
      pulse_mode_r <= mode_buf_r[ASPC_MODE_PULSE_BIT];
    end
  end

  // pulse method select
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dual_r <= 1'b0;
    end else if (commit && mode_buf_r[ASPC_MODE_PULSE_BIT] && !pulse_mode_r) begin
      dual_r <= 1'b0;
    end else if (pulse_mode_r && cmd_go[ASPC_CMD_DUAL]) begin
      dual_r <= 1'b1;
    end else if (pulse_mode_r && cmd_go[ASPC_CMD_STEPDIR]) begin
      dual_r <= 1'b0;
    end
  end

  // ****************************************************
  // servo period motion
  // ****************************************************
  logic tick;
  logic smooth_r, zero_ok, illegal;
  assign zero_ok = cmd_go[ASPC_CMD_ZERO] & ~moving & ~gear;
  assign illegal = cmd_go[ASPC_CMD_ZERO] & moving;

  aspc_period_tick u_tick (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .period_in(period_r),
    .tick_out(tick)
  );

  // a stop holds the goal at zero until a commit without a stop; else the axis would ramp back up
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      smooth_r <= 1'b0;
    end else if (cmd_go[ASPC_CMD_ABRUPT] || (cmd_go[ASPC_CMD_SMOOTH] && !gear)) begin
      smooth_r <= 1'b1;
    end else if (commit && !cmd_go[ASPC_CMD_SMOOTH]) begin
      smooth_r <= 1'b0;
    end
  end

  // velocity: signed magnitude ramp toward commanded or zero
  logic [31:0] vel_goal, step_v;
  assign vel_goal = smooth_r ? ASPC_ZERO32 : vel_r;
  always_comb begin
    if (acc_r == ASPC_ZERO32) begin
      step_v = (vel_goal - cur_vel_r);
    end else if ($signed(vel_goal) > $signed(cur_vel_r)) begin
      step_v = ($signed(vel_goal - cur_vel_r) > $signed(acc_r)) ? acc_r
             : (vel_goal - cur_vel_r);
    end else begin
      step_v = ($signed(cur_vel_r - vel_goal) > $signed(acc_r)) ? (ASPC_ZERO32 - acc_r)
             : (vel_goal - cur_vel_r);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur_vel_r <= ASPC_ZERO32;
    end else if (cmd_go[ASPC_CMD_ABRUPT]) begin
      cur_vel_r <= ASPC_ZERO32;
    end else if (tick) begin
      cur_vel_r <= cur_vel_r + step_v;
    end
  end

  // positions; each servo period advances plan and actual by the velocity
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      act_r <= ASPC_ZERO32;
      plan_r <= ASPC_ZERO32;
      tgt_r <= ASPC_ZERO32;
    end else if (zero_ok) begin
      act_r <= ASPC_ZERO32;
      plan_r <= ASPC_ZERO32;
      tgt_r <= ASPC_ZERO32;
    end else if (cmd_go[ASPC_CMD_SYNC] && (motion_r == ASPC_TRAP || motion_r == ASPC_SCURVE)) begin
      tgt_r <= act_r;
      plan_r <= act_r;
    end else begin
      if (commit) begin
        tgt_r <= tgt_buf_r;
      end
      if (tick) begin
        plan_r <= plan_r + cur_vel_r;
        act_r <= act_r + cur_vel_r;
      end
    end
  end

  // one step per period while moving; direction from velocity sign
  logic step_req;
  assign step_req = tick & moving;
  aspc_pulse_gen u_pulse (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .step_in(step_req),
    .dir_neg_in(cur_vel_r[31]),
    .dual_in(dual_r),
    .step_out(step_out),
    .dir_out(dir_out),
    .fwd_out(fwd_out),
    .rev_out(rev_out)
  );

  // ****************************************************
  // status and interrupts
  // ****************************************************
  logic err_r, moving_q_r;
  logic [ASPC_IRQ_W-1:0] irq_st_r, irq_msk_r, irq_set;
  logic stat_rd;
  assign stat_rd = rd_en & (paddr == ASPC_OFS_STAT);
  // error holds until status is read or cleared; a new event wins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err_r <= 1'b0;
    end else if (illegal) begin
      err_r <= 1'b1;
    end else if (stat_rd || (wr_en && paddr == ASPC_OFS_STAT && pwdata[ASPC_ST_ERR])) begin
      err_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      moving_q_r <= 1'b0;
    end else begin
      moving_q_r <= moving;
    end
  end

  assign irq_set = {commit, moving_q_r & ~moving, illegal};
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_st_r <= '0;
      irq_msk_r <= '0;
    end else begin
      if (wr_en && paddr == ASPC_OFS_IRQ_ST) begin
        irq_st_r <= (irq_st_r & ~pwdata[ASPC_IRQ_W-1:0]) | irq_set;
      end else begin
        irq_st_r <= irq_st_r | irq_set;
      end
      if (wr_en && paddr == ASPC_OFS_IRQ_MSK) begin
        irq_msk_r <= pwdata[ASPC_IRQ_W-1:0];
      end
    end
  end
  assign irq_out = |(irq_st_r & irq_msk_r);

  // ****************************************************
  // read data
  // ****************************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = ASPC_ZERO32;
    case (paddr)
      ASPC_OFS_CMD: rd_mux = {25'h0, pend_r};
      ASPC_OFS_MODE: rd_mux = {29'h0, mode_buf_r};
      ASPC_OFS_ACC: rd_mux = acc_buf_r;
      ASPC_OFS_VEL: rd_mux = vel_buf_r;
      ASPC_OFS_TGT: rd_mux = tgt_r;
      ASPC_OFS_STAT: rd_mux = {29'h0, err_r, dual_r, moving};
      ASPC_OFS_IRQ_ST: rd_mux = {29'h0, irq_st_r};
      ASPC_OFS_IRQ_MSK: rd_mux = {29'h0, irq_msk_r};
      ASPC_OFS_ACT_POS: rd_mux = act_r;
      ASPC_OFS_PLAN_POS: rd_mux = plan_r;
      ASPC_OFS_CUR_VEL: rd_mux = cur_vel_r;
      ASPC_OFS_PERIOD: rd_mux = period_r;
      default: rd_mux = ASPC_ZERO32;
    endcase
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata <= ASPC_ZERO32;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  property p_abrupt;
    @(posedge clk_in) disable iff (!rst_n_in) cmd_go[ASPC_CMD_ABRUPT] |=> cur_vel_r == ASPC_ZERO32;
  endproperty
  a_abrupt: assert property (p_abrupt) else $error("abrupt stop left velocity");
  property p_no_commit;
    @(posedge clk_in) disable iff (!rst_n_in) !commit |=> $stable(acc_r) && $stable(vel_r);
  endproperty
  a_no_commit: assert property (p_no_commit) else $error("active value moved without commit");
  property p_zero;
    @(posedge clk_in) disable iff (!rst_n_in) zero_ok |=> act_r == 0 && tgt_r == 0 && plan_r == 0;
  endproperty
  a_zero: assert property (p_zero) else $error("zero did not clear positions");
  property p_zero_moving;
    @(posedge clk_in) disable iff (!rst_n_in) cmd_go[ASPC_CMD_ZERO] && moving |=> err_r;
  endproperty
  a_zero_moving: assert property (p_zero_moving) else $error("illegal zero not flagged");
  property p_err_hold;
    @(posedge clk_in) disable iff (!rst_n_in) err_r && !stat_rd && !wr_en |=> err_r;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error dropped early");
  property p_sync;
    @(posedge clk_in) disable iff (!rst_n_in)
      cmd_go[ASPC_CMD_SYNC] && !zero_ok && (motion_r == ASPC_TRAP || motion_r == ASPC_SCURVE)
      |=> tgt_r == $past(act_r) && plan_r == $past(act_r);
  endproperty
  a_sync: assert property (p_sync) else $error("sync did not copy actual");
  property p_gear_smooth;
    @(posedge clk_in) disable iff (!rst_n_in)
      gear && !smooth_r && cmd_go[ASPC_CMD_SMOOTH] && !cmd_go[ASPC_CMD_ABRUPT] |=> !smooth_r;
  endproperty
  a_gear_smooth: assert property (p_gear_smooth) else $error("smooth stop took effect in gear");
  property p_default;
    @(posedge clk_in) disable iff (!rst_n_in)
      commit && mode_buf_r[ASPC_MODE_PULSE_BIT] && !pulse_mode_r |=> !dual_r;
  endproperty
  a_default: assert property (p_default) else $error("pulse method not defaulted");
  property p_slow;
    @(posedge clk_in) disable iff (!rst_n_in)
      tick && smooth_r && moving && acc_r != 0 && !cmd_go[ASPC_CMD_ABRUPT]
      |=> ($signed(cur_vel_r) >= 0 ? cur_vel_r : -cur_vel_r)
          < ($signed($past(cur_vel_r)) >= 0 ? $past(cur_vel_r) : -$past(cur_vel_r));
  endproperty
  a_slow: assert property (p_slow) else $error("smooth stop did not slow");
  c_smooth: cover property (@(posedge clk_in) smooth_r ##[1:1000] !moving);
  c_illegal: cover property (@(posedge clk_in) illegal);
  c_dual: cover property (@(posedge clk_in) dual_r && fwd_out);
endmodule

// ===== sim/aspc_motor_model.sv
// pulse-counting model of the stepper or servo drive on the pulse outputs
module aspc_motor_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic step_in,
  input wire logic dir_in,
  input wire logic fwd_in,
  input wire logic rev_in,
  output int step_cnt_out,
  output int fwd_cnt_out,
  output int rev_cnt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // a drive only counts clocks with a pulse high; it never answers, so nothing flows back to the block
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      step_cnt_out <= 0;
      fwd_cnt_out <= 0;
      rev_cnt_out <= 0;
    end else begin
      step_cnt_out <= step_cnt_out + int'(step_in);
      fwd_cnt_out <= fwd_cnt_out + int'(fwd_in);
      rev_cnt_out <= rev_cnt_out + int'(rev_in);
    end
  end
endmodule

// ===== sim/axis_stop_position_commit_tb_top.sv
// self-checking bench of the axis stop and position commit block
module axis_stop_position_commit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import aspc_pkg::*;
  logic clk_in, rst_n_in, psel, penable, pwrite, pready, pslverr;
  logic step_out, dir_out, fwd_out, rev_out, irq_out, slv_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, act, prev;
  int err_count, num_checks, n, s0, f0, r0;
  int step_cnt, fwd_cnt, rev_cnt;
  aspc_axis uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .step_out(step_out), .dir_out(dir_out), .fwd_out(fwd_out),
    .rev_out(rev_out), .irq_out(irq_out));
  aspc_motor_model drive (.clk_in(clk_in), .rst_n_in(rst_n_in), .step_in(step_out),
    .dir_in(dir_out), .fwd_in(fwd_out), .rev_in(rev_out), .step_cnt_out(step_cnt),
    .fwd_cnt_out(fwd_cnt), .rev_cnt_out(rev_cnt));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // ****************************************
  // bus access and comparison
  // ****************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  // command bit plus the commit bit in one write
  function automatic logic [31:0] cb(input int unsigned b);
    return (32'h0000_0001 << b) | 32'h0000_0001;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chkb(input logic c);
    chk({31'h0, c}, 32'h0000_0001);
  endtask
  task automatic wait_vel(input logic [31:0] v);
    int k;
    k = 0;
    do begin
      rdr(ASPC_OFS_CUR_VEL);
      k++;
    end while (rd !== v && k < 200);
    // a speed that never arrives counts as a mismatch
    if (rd !== v) err_count++;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    test_done();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {rst_n_in, psel, penable, pwrite, paddr, pwdata} = '0;
    err_count = 0;
    num_checks = 0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rdr(ASPC_OFS_STAT); chk(rd, 32'h0000_0000);
    rdr(ASPC_OFS_PERIOD); chk(rd, ASPC_PERIOD_RST);
    rdr(8'hfc); chkb(slv_err === 1'b1);
    wr(ASPC_OFS_PERIOD, 32'h0000_0004);
    wr(ASPC_OFS_MODE, 32'h0000_0006);
    wr(ASPC_OFS_ACC, 32'h0000_0000);
    wr(ASPC_OFS_VEL, 32'h0000_0002);
    repeat (12) @(posedge clk_in);
    rdr(ASPC_OFS_CUR_VEL); chk(rd, 32'h0000_0000);
    s0 = step_cnt;
    wr(ASPC_OFS_CMD, 32'h0000_0001);
    wait_vel(32'h0000_0002); chk(rd, 32'h0000_0002);
    rdr(ASPC_OFS_STAT); chk(rd & 32'h3, 32'h0000_0001);
    repeat (40) @(posedge clk_in);
    chkb(step_cnt > s0 && fwd_cnt == 0 && rev_cnt == 0);
    // zero while moving is refused and flagged
    wr(ASPC_OFS_IRQ_MSK, 32'h0000_0001);
    wr(ASPC_OFS_CMD, cb(ASPC_CMD_ZERO));
    rdr(ASPC_OFS_ACT_POS); chkb(rd !== 32'h0000_0000);
    chkb(irq_out === 1'b1);
    rdr(ASPC_OFS_STAT); chk(rd[ASPC_ST_ERR], 1'b1);
    rdr(ASPC_OFS_STAT); chk(rd[ASPC_ST_ERR], 1'b0);
    wr(ASPC_OFS_IRQ_ST, 32'h0000_0001);
    @(posedge clk_in);
    chkb(irq_out === 1'b0);
    // separate forward and reverse pulses for negative then positive speed, then step and direction
    wr(ASPC_OFS_CMD, cb(ASPC_CMD_DUAL));
    wr(ASPC_OFS_VEL, 32'hffff_fffe);
    s0 = step_cnt;
    wr(ASPC_OFS_CMD, 32'h0000_0001);
    rdr(ASPC_OFS_STAT); chk(rd[ASPC_ST_DUAL], 1'b1);
    r0 = rev_cnt;
    repeat (40) @(posedge clk_in);
    chkb(rev_cnt > r0 && step_cnt == s0 && dir_out === 1'b0);
    f0 = fwd_cnt;
    wr(ASPC_OFS_VEL, 32'h0000_0002);
    wr(ASPC_OFS_CMD, 32'h0000_0001);
    repeat (40) @(posedge clk_in);
    chkb(fwd_cnt > f0);
    wr(ASPC_OFS_CMD, cb(ASPC_CMD_STEPDIR));
    rdr(ASPC_OFS_STAT); chk(rd[ASPC_ST_DUAL], 1'b0);
    wr(ASPC_OFS_VEL, 32'hffff_fffe);
    wr(ASPC_OFS_CMD, 32'h0000_0001);
    repeat (12) @(posedge clk_in);
    chkb(dir_out === 1'b1);
    // smooth stop ramps down one step per servo period
    wr(ASPC_OFS_ACC, 32'h0000_0001);
    wr(ASPC_OFS_VEL, 32'h0000_0008);
    wr(ASPC_OFS_CMD, 32'h0000_0001);
    wait_vel(32'h0000_0008);
    wr(ASPC_OFS_CMD, cb(ASPC_CMD_SMOOTH));
    prev = 32'h0000_0008;
    n = 0;
    do begin
      rdr(ASPC_OFS_CUR_VEL);
      chkb(rd <= prev && prev - rd <= 32'h1);
      prev = rd;
      n++;
    end while (rd !== 32'h0000_0000 && n < 200);
    chkb(n >= 7);
    wr(ASPC_OFS_VEL, 32'h0000_0000);
    wr(ASPC_OFS_CMD, 32'h0000_0001);
    // copy actual position into target in trapezoid mode
    wr(ASPC_OFS_MODE, 32'h0000_0004);
    // the mode must be active before the sync is committed
    wr(ASPC_OFS_CMD, 32'h0000_0001);
    wr(ASPC_OFS_CMD, cb(ASPC_CMD_SYNC));
    rdr(ASPC_OFS_ACT_POS); act = rd;
    rdr(ASPC_OFS_TGT); chkb(rd === act && act !== 32'h0);
    rdr(ASPC_OFS_PLAN_POS); chk(rd, act);
    wr(ASPC_OFS_CMD, cb(ASPC_CMD_ZERO));
    rdr(ASPC_OFS_ACT_POS); chk(rd, 32'h0000_0000);
    rdr(ASPC_OFS_PLAN_POS); chk(rd, 32'h0000_0000);
    rdr(ASPC_OFS_TGT); chk(rd, 32'h0000_0000);
    rdr(ASPC_OFS_STAT); chk(rd[ASPC_ST_ERR], 1'b0);
    // leaving and re-entering pulse output drops back to step plus direction
    wr(ASPC_OFS_CMD, cb(ASPC_CMD_DUAL));
    wr(ASPC_OFS_MODE, 32'h0000_0002);
    wr(ASPC_OFS_CMD, 32'h0000_0001);
    wr(ASPC_OFS_MODE, 32'h0000_0006);
    wr(ASPC_OFS_CMD, 32'h0000_0001);
    rdr(ASPC_OFS_STAT); chk(rd[ASPC_ST_DUAL], 1'b0);
    // abrupt stop gives zero speed at once, not a ramp
    wr(ASPC_OFS_VEL, 32'h0000_0008);
    wr(ASPC_OFS_CMD, 32'h0000_0001);
    wait_vel(32'h0000_0008);
    wr(ASPC_OFS_VEL, 32'h0000_0000);
    wr(ASPC_OFS_CMD, cb(ASPC_CMD_ABRUPT));
    rdr(ASPC_OFS_CUR_VEL); chk(rd, 32'h0000_0000);
    repeat (12) @(posedge clk_in);
    rdr(ASPC_OFS_STAT); chk(rd[ASPC_ST_MOVING], 1'b0);
    // in gear mode zero and sync leave the positions alone
    wr(ASPC_OFS_MODE, 32'h0000_0007);
    wr(ASPC_OFS_CMD, 32'h0000_0001);
    rdr(ASPC_OFS_ACT_POS); act = rd;
    wr(ASPC_OFS_CMD, cb(ASPC_CMD_ZERO));
    rdr(ASPC_OFS_ACT_POS); chkb(rd === act && act !== 32'h0);
    rdr(ASPC_OFS_STAT); chk(rd[ASPC_ST_ERR], 1'b0);
    wr(ASPC_OFS_CMD, cb(ASPC_CMD_SYNC));
    rdr(ASPC_OFS_TGT); chk(rd, 32'h0000_0000);
    wr(ASPC_OFS_VEL, 32'h0000_0008);
    wr(ASPC_OFS_CMD, 32'h0000_0001);
    wait_vel(32'h0000_0008);
    wr(ASPC_OFS_CMD, cb(ASPC_CMD_SMOOTH));
    repeat (12) @(posedge clk_in);
    rdr(ASPC_OFS_CUR_VEL); chk(rd, 32'h0000_0008);
    test_done();
  end
endmodule
